// ### src/ahbw_device_end.sv
// device end of the host bus: wait generation, address latch, data capture
`timescale 1ns/1ps
`include "ahbw_defs.svh"
module ahbw_device_end #(
  parameter int DW = 32,
  parameter bit FAST_READ_SUPPORT = 1'b1,
  parameter int OTHER_WAIT_CYC = 0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic turboEnable,
  ahbw_bus_if.device bus,
  output logic [15:1] accessAddr,
  output logic [DW/8-1:0] accessBe,
  output logic accessIsQm,
  input wire logic [DW-1:0] rdData,
  output logic rdTaken,
  output logic wrValid,
  output logic [15:1] wrAddr,
  output logic [DW/8-1:0] wrBe,
  output logic [DW-1:0] wrData,
  output logic wrToQm,
  output logic busy
);
  localparam int WW = `AHBW_WAIT_W;
  localparam int BW = DW / 8;
  localparam logic [WW-1:0] BANK_CYC = WW'(`AHBW_BANK_WAIT_CYC);
  localparam logic [WW-1:0] RD_TURBO_CYC = WW'(`AHBW_RD_TURBO_CYC);
  localparam logic [WW-1:0] RD_NORMAL_CYC = WW'(`AHBW_RD_NORMAL_CYC);
  localparam logic [WW-1:0] WR_PLAIN_CYC = WW'(`AHBW_WR_PLAIN_CYC);
  localparam logic [WW-1:0] WR_DSEL_CYC = WW'(`AHBW_WR_DSEL_CYC);
  localparam logic [WW-1:0] OTHER_CYC = WW'(OTHER_WAIT_CYC);

  if (DW != 16 && DW != 32) begin : g_bad_dw
    $error("ahbw_device_end: DW must be 16 or 32");
  end
  if (OTHER_WAIT_CYC < 0 || OTHER_WAIT_CYC >= (1 << WW)) begin : g_bad_other
    $error("ahbw_device_end: OTHER_WAIT_CYC out of range");
  end
  if (`AHBW_WR_PLAIN_CYC > `AHBW_WR_MAX_CYC) begin : g_bad_wr
    $error("ahbw_device_end: plain write wait above its ceiling");
  end

  ahbw_pkg::ahbw_dev_state_t state_reg;
  ahbw_pkg::ahbw_dev_state_t state_next;
  logic [15:1] addrLat_reg;
  logic qualLat_reg;
  logic [BW-1:0] beLatN_reg;
  logic [WW-1:0] wrWait_reg;
  logic wrQm_reg;
  logic [DW-1:0] rdOut_reg;
  logic rdTaken_reg;
  logic wrValid_reg;
  logic [15:1] wrAddr_reg;
  logic [BW-1:0] wrBe_reg;
  logic [DW-1:0] wrData_reg;
  logic wrToQm_reg;
  logic timerLast;

  // address path: transparent while the latch strobe is low, frozen at its rise
  wire transparent = ~bus.addrLatchStrobeN;
  wire [15:1] effAddr = transparent ? bus.addr : addrLat_reg;
  wire effQual = transparent ? bus.addrQualifier : qualLat_reg;
  wire [BW-1:0] effBeN = transparent ? bus.byteLaneSelectN : beLatN_reg;

  // target decode
  wire dataSel = ~bus.dataPortSelectN;
  wire isBank = ~dataSel & effQual & (effAddr == `AHBW_BANK_SEL_ADDR);
  wire isQm = dataSel | (effQual & (effAddr == `AHBW_QM_DATA_ADDR));
  wire turboOk = FAST_READ_SUPPORT & turboEnable;

  // wait lengths in cycles, counting the cycle in which ready first drops
  wire [WW-1:0] qmRdCyc = turboOk ? RD_TURBO_CYC : RD_NORMAL_CYC;
  wire [WW-1:0] qmWrCyc = dataSel ? WR_DSEL_CYC : WR_PLAIN_CYC;
  wire [WW-1:0] rdWaitCyc = isBank ? BANK_CYC : (isQm ? qmRdCyc : OTHER_CYC);
  wire [WW-1:0] wrWaitCyc = isBank ? BANK_CYC : (isQm ? qmWrCyc : OTHER_CYC);

  // access events
  wire inIdle = (state_reg == ahbw_pkg::DEV_IDLE);
  wire inReadWait = (state_reg == ahbw_pkg::DEV_READ_WAIT);
  wire inReadHold = (state_reg == ahbw_pkg::DEV_READ_HOLD);
  wire inWriteWait = (state_reg == ahbw_pkg::DEV_WRITE_WAIT);
  wire inWriteAct = (state_reg == ahbw_pkg::DEV_WRITE_ACT);
  // a read wins when both strobes fall together
  wire rdStart = inIdle & ~bus.readStrobeN;
  wire wrStart = inIdle & bus.readStrobeN & ~bus.writeStrobeN;
  wire wrRelease = inWriteAct & bus.writeStrobeN;
  wire rdNeedsWait = (rdWaitCyc != '0);
  wire wrNeedsWait = (wrWait_reg != '0);
  wire rdLongWait = (rdWaitCyc > {{(WW-1){1'b0}}, 1'b1});
  wire wrLongWait = (wrWait_reg > {{(WW-1){1'b0}}, 1'b1});
  wire timerLoad = (rdStart & rdLongWait) | (wrRelease & wrLongWait);
  wire [WW-1:0] timerVal = rdStart ? (rdWaitCyc - 1'b1) : (wrWait_reg - 1'b1);
  wire rdSample = rdStart | inReadWait;

  // ready drops combinationally in the cycle the read strobe falls
  wire rdyLowRead = (rdStart & rdNeedsWait) | inReadWait;
  // and in the cycle the write strobe rises
  wire rdyLowWrite = (wrRelease & wrNeedsWait) | inWriteWait;
  // an idle bus shows no stall once any write wait has ended
  assign bus.busWaitRelease = ~(rdyLowRead | rdyLowWrite);

  // read data is driven from a flop from the start until the strobe goes away
  assign bus.devDataOut = rdOut_reg;
  assign bus.devDataDriveN = ~(~bus.readStrobeN & (rdStart | inReadWait | inReadHold));

  // local device select: plain decode, no clock in the path
  wire ldevHit = effQual & (effAddr[`AHBW_LDEV_MSB:`AHBW_LDEV_LSB] == `AHBW_LDEV_BASE);
  assign bus.localDeviceSelectN = ~ldevHit;

  assign accessAddr = effAddr;
  assign accessBe = ~effBeN;
  assign accessIsQm = isQm;
  assign rdTaken = rdTaken_reg;
  assign wrValid = wrValid_reg;
  assign wrAddr = wrAddr_reg;
  assign wrBe = wrBe_reg;
  assign wrData = wrData_reg;
  assign wrToQm = wrToQm_reg;
  assign busy = ~inIdle;

  ahbw_wait_timer #(
    .W(WW)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .load(timerLoad),
    .loadVal(timerVal),
    .lastCycle(timerLast)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ahbw_pkg::DEV_IDLE: begin
        if (rdStart) begin
          state_next = rdLongWait ? ahbw_pkg::DEV_READ_WAIT : ahbw_pkg::DEV_READ_HOLD;
        end else if (wrStart) begin
          state_next = ahbw_pkg::DEV_WRITE_ACT;
        end
      end
      ahbw_pkg::DEV_READ_WAIT: begin
        if (timerLast) begin
          state_next = ahbw_pkg::DEV_READ_HOLD;
        end
      end
      ahbw_pkg::DEV_READ_HOLD: begin
        if (bus.readStrobeN) begin
          state_next = ahbw_pkg::DEV_IDLE;
        end
      end
      ahbw_pkg::DEV_WRITE_ACT: begin
        if (bus.writeStrobeN) begin
          state_next = wrLongWait ? ahbw_pkg::DEV_WRITE_WAIT : ahbw_pkg::DEV_IDLE;
        end
      end
      ahbw_pkg::DEV_WRITE_WAIT: begin
        // a new strobe seen here is served from idle once the wait ends
        if (timerLast) begin
          state_next = ahbw_pkg::DEV_IDLE;
        end
      end
      default: begin
        state_next = ahbw_pkg::DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ahbw_pkg::DEV_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // address latch follows the pins while its strobe is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addrLat_reg <= '0;
      qualLat_reg <= 1'b0;
      beLatN_reg <= '1;
    end else if (clkEn && transparent) begin
      addrLat_reg <= bus.addr;
      qualLat_reg <= bus.addrQualifier;
      beLatN_reg <= bus.byteLaneSelectN;
    end
  end

  // write wait is fixed at strobe fall: data select may drop with the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrWait_reg <= '0;
      wrQm_reg <= 1'b0;
    end else if (clkEn && wrStart) begin
      wrWait_reg <= wrWaitCyc;
      wrQm_reg <= isQm;
    end
  end

  // read data frozen once ready has risen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdOut_reg <= '0;
      rdTaken_reg <= 1'b0;
    end else if (clkEn) begin
      rdTaken_reg <= rdStart;
      if (rdSample) begin
        rdOut_reg <= rdData;
      end
    end
  end

  // write capture on the release edge of the write strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrValid_reg <= 1'b0;
      wrAddr_reg <= '0;
      wrBe_reg <= '0;
      wrData_reg <= '0;
      wrToQm_reg <= 1'b0;
    end else if (clkEn) begin
      wrValid_reg <= wrRelease;
      if (wrRelease) begin
        wrAddr_reg <= effAddr;
        wrBe_reg <= ~effBeN;
        wrData_reg <= bus.busData;
        wrToQm_reg <= wrQm_reg;
      end
    end
  end
endmodule : ahbw_device_end

// ### src/ahbw_defs.svh
// constants of the asynchronous host bus wait port
// Contract
// - host keeps strobe low while ready low
// - next access may start while ready low
// - ready low within 8 ns of read
// - write wait starts within 8 ns of release
// - bank select access has no wait
// - data register read waits 40 ns turbo
// - data register read waits 80 ns normal
// - data register write waits 36 ns, max 50
// - data-select write waits about 85 ns
// - read data valid at ready rise, held
// - write data captured at strobe release
// - address strobe rise latches address, qualifier, lanes
// - low address strobe makes latch transparent
// - local device select decoded within 5 ns
// - data select asserted before the strobe
// - turbo read only with matching driver
`ifndef AHBW_DEFS_SVH
`define AHBW_DEFS_SVH

`define AHBW_CLK_PERIOD_NS 40
`define AHBW_RDY_LOW_MAX_NS 8
`define AHBW_WR_RDY_LOW_MAX_NS 8
`define AHBW_LDEV_MAX_NS 5
`define AHBW_RD_DATA_MAX_NS 0.8
`define AHBW_BANK_WAIT_NS 0
`define AHBW_RD_WAIT_TURBO_NS 40
`define AHBW_RD_WAIT_NORMAL_NS 80
`define AHBW_WR_WAIT_NS 36
`define AHBW_WR_WAIT_MAX_NS 50
`define AHBW_WR_WAIT_DSEL_NS 85

// least times round up, longest times round down
`define AHBW_CEIL_CYC(ns) (((ns) + `AHBW_CLK_PERIOD_NS - 1) / `AHBW_CLK_PERIOD_NS)
`define AHBW_FLOOR_CYC(ns) ((ns) / `AHBW_CLK_PERIOD_NS)
`define AHBW_BANK_WAIT_CYC `AHBW_CEIL_CYC(`AHBW_BANK_WAIT_NS)
`define AHBW_RD_TURBO_CYC `AHBW_CEIL_CYC(`AHBW_RD_WAIT_TURBO_NS)
`define AHBW_RD_NORMAL_CYC `AHBW_CEIL_CYC(`AHBW_RD_WAIT_NORMAL_NS)
`define AHBW_WR_PLAIN_CYC `AHBW_CEIL_CYC(`AHBW_WR_WAIT_NS)
`define AHBW_WR_MAX_CYC `AHBW_FLOOR_CYC(`AHBW_WR_WAIT_MAX_NS)
`define AHBW_WR_DSEL_CYC `AHBW_CEIL_CYC(`AHBW_WR_WAIT_DSEL_NS)

`define AHBW_LDEV_MSB 15
`define AHBW_LDEV_LSB 4
`define AHBW_BANK_SEL_ADDR 15'h0007
`define AHBW_QM_DATA_ADDR 15'h0004
`define AHBW_LDEV_BASE 12'h030
`define AHBW_HOST_RD_MIN_CYC 2
`define AHBW_WAIT_W 4

`endif

// ### src/ahbw_pkg.sv
// types shared by both ends of the host bus wait port
package ahbw_pkg;

  typedef enum logic [4:0] {
    DEV_IDLE = 5'h01,
    DEV_READ_WAIT = 5'h02,
    DEV_READ_HOLD = 5'h04,
    DEV_WRITE_ACT = 5'h08,
    DEV_WRITE_WAIT = 5'h10
  } ahbw_dev_state_t;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'h1,
    HOST_SETUP = 4'h2,
    HOST_ACTIVE = 4'h4,
    HOST_FINISH = 4'h8
  } ahbw_host_state_t;

endpackage : ahbw_pkg

// ### src/ahbw_bus_if.sv
// pins of the asynchronous host bus between host and device
`timescale 1ns/1ps
interface ahbw_bus_if #(
  parameter int DW = 32
) ();
  logic [15:1] addr;
  logic addrQualifier;
  logic [DW/8-1:0] byteLaneSelectN;
  logic addrLatchStrobeN;
  logic readStrobeN;
  logic writeStrobeN;
  logic dataPortSelectN;
  logic busWaitRelease;
  logic localDeviceSelectN;
  logic [DW-1:0] hostDataOut;
  logic hostDataDriveN;
  logic [DW-1:0] devDataOut;
  logic devDataDriveN;
  logic [DW-1:0] busData;

  // undriven data bus reads as zero
  assign busData = !devDataDriveN ? devDataOut : (!hostDataDriveN ? hostDataOut : '0);

  modport device (
    input addr, addrQualifier, byteLaneSelectN, addrLatchStrobeN, readStrobeN,
    input writeStrobeN, dataPortSelectN, busData,
    output busWaitRelease, localDeviceSelectN, devDataOut, devDataDriveN
  );

  modport host (
    output addr, addrQualifier, byteLaneSelectN, addrLatchStrobeN, readStrobeN,
    output writeStrobeN, dataPortSelectN, hostDataOut, hostDataDriveN,
    input busWaitRelease, localDeviceSelectN, busData
  );
endinterface : ahbw_bus_if

// ### src/ahbw_wait_timer.sv
// down counter that times the ready-low wait
`timescale 1ns/1ps
module ahbw_wait_timer #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic lastCycle
);
  logic [W-1:0] count_reg;

  if (W < 2 || W > 8) begin : g_bad_width
    $error("ahbw_wait_timer: W out of range");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (clkEn) begin
      if (load) begin
        count_reg <= loadVal;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign lastCycle = (count_reg == {{(W-1){1'b0}}, 1'b1});
endmodule : ahbw_wait_timer

// ### src/ahbw_host_end.sv
// host end of the host bus: runs one read or write per command
`timescale 1ns/1ps
`include "ahbw_defs.svh"
module ahbw_host_end #(
  parameter int DW = 32,
  parameter int RD_MIN_CYC = `AHBW_HOST_RD_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  ahbw_bus_if.host bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [15:1] cmdAddr,
  input wire logic cmdQual,
  input wire logic [DW/8-1:0] cmdBe,
  input wire logic [DW-1:0] cmdWdata,
  input wire logic cmdDataPort,
  input wire logic cmdAddrStrobe,
  output logic rspValid,
  output logic [DW-1:0] rspData
);
  localparam int BW = DW / 8;
  localparam logic [3:0] MIN_LAST = 4'(RD_MIN_CYC - 1);

  if (DW != 16 && DW != 32) begin : g_bad_dw
    $error("ahbw_host_end: DW must be 16 or 32");
  end
  // the device needs one cycle to put read data on its flop
  if (RD_MIN_CYC < 2 || RD_MIN_CYC > 15) begin : g_bad_min
    $error("ahbw_host_end: RD_MIN_CYC must be 2..15");
  end

  ahbw_pkg::ahbw_host_state_t state_reg;
  ahbw_pkg::ahbw_host_state_t state_next;
  logic write_reg;
  logic [15:1] addr_reg;
  logic qual_reg;
  logic [BW-1:0] be_reg;
  logic [DW-1:0] wdata_reg;
  logic dsel_reg;
  logic ads_reg;
  logic [3:0] cnt_reg;
  logic rspValid_reg;
  logic [DW-1:0] rspData_reg;

  wire inIdle = (state_reg == ahbw_pkg::HOST_IDLE);
  wire inSetup = (state_reg == ahbw_pkg::HOST_SETUP);
  wire inActive = (state_reg == ahbw_pkg::HOST_ACTIVE);
  wire accept = inIdle & cmdValid;
  // strobe may only rise once ready is high
  wire done = inActive & (cnt_reg >= MIN_LAST) & bus.busWaitRelease;

  assign cmdReady = inIdle;
  // no wait for ready here: a new access may start while it is low
  assign bus.addr = addr_reg;
  assign bus.addrQualifier = qual_reg;
  assign bus.byteLaneSelectN = ~be_reg;
  // address strobe rises after the setup cycle, or stays low
  assign bus.addrLatchStrobeN = ads_reg & ~inSetup;
  // data select leads the strobe by the setup cycle
  assign bus.dataPortSelectN = ~(dsel_reg & ~inIdle);
  assign bus.readStrobeN = ~(~write_reg & inActive);
  assign bus.writeStrobeN = ~(write_reg & inActive);
  assign bus.hostDataOut = wdata_reg;
  assign bus.hostDataDriveN = ~(write_reg & ~inIdle);
  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ahbw_pkg::HOST_IDLE: begin
        if (cmdValid) begin
          state_next = ahbw_pkg::HOST_SETUP;
        end
      end
      ahbw_pkg::HOST_SETUP: begin
        state_next = ahbw_pkg::HOST_ACTIVE;
      end
      ahbw_pkg::HOST_ACTIVE: begin
        if (done) begin
          state_next = ahbw_pkg::HOST_FINISH;
        end
      end
      ahbw_pkg::HOST_FINISH: begin
        state_next = ahbw_pkg::HOST_IDLE;
      end
      default: begin
        state_next = ahbw_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ahbw_pkg::HOST_IDLE;
      cnt_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= inActive ? cnt_reg + 1'b1 : 4'h0;
    end
  end

  // command fields stay on the pins through the finish cycle for hold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_reg <= 1'b0;
      addr_reg <= '0;
      qual_reg <= 1'b0;
      be_reg <= '0;
      wdata_reg <= '0;
      dsel_reg <= 1'b0;
      ads_reg <= 1'b0;
    end else if (clkEn && accept) begin
      write_reg <= cmdWrite;
      addr_reg <= cmdAddr;
      qual_reg <= cmdQual;
      be_reg <= cmdBe;
      wdata_reg <= cmdWdata;
      dsel_reg <= cmdDataPort;
      ads_reg <= cmdAddrStrobe;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rspValid_reg <= 1'b0;
      rspData_reg <= '0;
    end else if (clkEn) begin
      rspValid_reg <= done & ~write_reg;
      if (done && !write_reg) begin
        rspData_reg <= bus.busData;
      end
    end
  end
endmodule : ahbw_host_end

// ### verification/ahbw_bus_checker.sv
// assertions on the host bus between the host end and the device end
`timescale 1ns/1ps
`include "ahbw_defs.svh"
module ahbw_bus_checker #(
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:1] addr,
  input wire logic addrQualifier,
  input wire logic addrLatchStrobeN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic dataPortSelectN,
  input wire logic busWaitRelease,
  input wire logic localDeviceSelectN,
  input wire logic devDataDriveN
);
  logic [15:1] heldAddr_reg;
  logic heldQual_reg;
  wire [15:1] effAddr;
  wire effQual;
  wire qmTarget;
  wire bankTarget;
  // own copy of the address latch, so decode checks follow the frozen value
  assign effAddr = !addrLatchStrobeN ? addr : heldAddr_reg;
  assign effQual = !addrLatchStrobeN ? addrQualifier : heldQual_reg;
  assign qmTarget = !dataPortSelectN || (effAddr == `AHBW_QM_DATA_ADDR && effQual);
  assign bankTarget = dataPortSelectN && effAddr == `AHBW_BANK_SEL_ADDR && effQual;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      heldAddr_reg <= 15'h0000;
      heldQual_reg <= 1'h0;
    end else if (!addrLatchStrobeN) begin
      heldAddr_reg <= addr;
      heldQual_reg <= addrQualifier;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_IDLE_READY: assert property ((readStrobeN && writeStrobeN) [*4] |-> busWaitRelease)
    else $error("ready low on idle bus");
  AST_STROBE_HELD: assert property ((!readStrobeN && !busWaitRelease) |=> !readStrobeN)
    else $error("read strobe released during wait");
  AST_QM_RD_WAIT: assert property (($fell(readStrobeN) && qmTarget) |-> !busWaitRelease ##[1:2] busWaitRelease)
    else $error("data register read wait wrong");
  AST_BANK_RD: assert property (($fell(readStrobeN) && bankTarget) |-> busWaitRelease)
    else $error("bank select read waited");
  AST_BANK_WR: assert property (($rose(writeStrobeN) && bankTarget) |-> busWaitRelease [*2])
    else $error("bank select write waited");
  AST_QM_WR: assert property (($rose(writeStrobeN) && qmTarget && dataPortSelectN) |-> !busWaitRelease ##1 busWaitRelease)
    else $error("data register write wait wrong");
  // a back-to-back read may pull ready low again right as the write wait ends
  AST_DSEL_WR: assert property (($rose(writeStrobeN) && !dataPortSelectN) |-> !busWaitRelease [*3] ##1 (busWaitRelease || $fell(readStrobeN)))
    else $error("data select write wait wrong");
  AST_LDEV: assert property (localDeviceSelectN == !(effAddr[`AHBW_LDEV_MSB:`AHBW_LDEV_LSB] == `AHBW_LDEV_BASE && effQual))
    else $error("local device select decode wrong");
  AST_RD_DRIVE: assert property ((!readStrobeN && !$past(readStrobeN)) |-> !devDataDriveN)
    else $error("read data not driven");
  AST_RD_RELEASE: assert property ($rose(readStrobeN) |-> devDataDriveN)
    else $error("read data driven after strobe");
endmodule : ahbw_bus_checker

// ### verification/async_host_bus_wait_port_test.sv
// bench joining host end and device end, checking waits and data
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin \
  $display("unexpected %s exp %0h got %0h", nm, ex, gt); miscompares++; end end
module async_host_bus_wait_port_test;
  typedef struct {logic wr; logic [15:1] addr; logic qual; logic dport; logic ads; logic turbo; int wt; logic qm;} ahbw_case_t;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic clkEn = 1'h1;
  logic turboEnable = 1'h0;
  logic cmdValid = 1'h0;
  logic cmdWrite = 1'h0;
  logic [15:1] cmdAddr = 15'h0000;
  logic cmdQual = 1'h0;
  logic [3:0] cmdBe = 4'h0;
  logic [31:0] cmdWdata = 32'h00000000;
  logic cmdDataPort = 1'h0;
  logic cmdAddrStrobe = 1'h0;
  logic cmdReady, rspValid, rdTaken, wrValid, wrToQm, busy, accessIsQm;
  logic [31:0] rspData, rdData, wrData;
  logic [15:1] accessAddr, wrAddr;
  logic [3:0] accessBe, wrBe;
  int miscompares = 0;
  int samplesChecked = 0;
  int lowCnt = 0;
  int cycles = 0;
  int wrCount = 0;
  int rdCount = 0;
  logic rdQm = 1'h0;
  logic [3:0] rdBe = 4'h0;
  ahbw_case_t tbl[10];
  ahbw_bus_if #(.DW(32)) ahbw_bus_if_inst ();
  // read data is a function of the address, so a stale latch shows up
  assign rdData = {2'h1, ~accessAddr, accessAddr};
  ahbw_host_end #(.DW(32)) ahbw_host_end_inst (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .bus(ahbw_bus_if_inst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdQual(cmdQual), .cmdBe(cmdBe),
    .cmdWdata(cmdWdata), .cmdDataPort(cmdDataPort), .cmdAddrStrobe(cmdAddrStrobe),
    .rspValid(rspValid), .rspData(rspData));
  ahbw_device_end #(.DW(32)) ahbw_device_end_inst (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .turboEnable(turboEnable), .bus(ahbw_bus_if_inst),
    .accessAddr(accessAddr), .accessBe(accessBe), .accessIsQm(accessIsQm), .rdData(rdData),
    .rdTaken(rdTaken), .wrValid(wrValid), .wrAddr(wrAddr), .wrBe(wrBe), .wrData(wrData),
    .wrToQm(wrToQm), .busy(busy));
  ahbw_bus_checker #(.DW(32)) ahbw_bus_checker_inst (
    .ref_clk(ref_clk), .rst(rst), .addr(ahbw_bus_if_inst.addr), .addrQualifier(ahbw_bus_if_inst.addrQualifier),
    .addrLatchStrobeN(ahbw_bus_if_inst.addrLatchStrobeN), .readStrobeN(ahbw_bus_if_inst.readStrobeN),
    .writeStrobeN(ahbw_bus_if_inst.writeStrobeN), .dataPortSelectN(ahbw_bus_if_inst.dataPortSelectN),
    .busWaitRelease(ahbw_bus_if_inst.busWaitRelease),
    .localDeviceSelectN(ahbw_bus_if_inst.localDeviceSelectN), .devDataDriveN(ahbw_bus_if_inst.devDataDriveN));
  task automatic results();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic waitIdle();
    int n;
    n = 0;
    while ((busy !== 1'h0 || cmdReady !== 1'h1) && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : waitIdle
  // settle off runs commands back to back, so waits overlap the next command
  task automatic access(input int i, input bit settle);
    int c0;
    int n;
    n = 0;
    while (cmdReady !== 1'h1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    c0 = lowCnt;
    turboEnable = tbl[i].turbo;
    cmdWrite = tbl[i].wr;
    cmdAddr = tbl[i].addr;
    cmdQual = tbl[i].qual;
    cmdDataPort = tbl[i].dport;
    cmdAddrStrobe = tbl[i].ads;
    cmdWdata = {2'h2, ~tbl[i].addr, tbl[i].addr};
    cmdBe = 4'hF ^ 4'(i);
    cmdValid = 1'h1;
    @(negedge ref_clk);
    cmdValid = 1'h0;
    if (!tbl[i].wr) begin
      n = 0;
      while (rspValid !== 1'h1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK("read data", {2'h1, ~tbl[i].addr, tbl[i].addr}, rspData)
      `CHK("read target", tbl[i].qm, rdQm)
      `CHK("read lanes", cmdBe, rdBe)
    end
    if (settle) begin
      waitIdle();
      `CHK("wait cycles", tbl[i].wt, lowCnt - c0)
      if (tbl[i].wr) begin
        `CHK("write data", cmdWdata, wrData)
        `CHK("write lanes", cmdBe, wrBe)
        `CHK("write addr", tbl[i].addr, wrAddr)
        `CHK("write to data port", tbl[i].qm, wrToQm)
      end
    end
  endtask : access
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // ceiling well above two passes of ten accesses
  always @(posedge ref_clk) begin
    cycles++;
    if (ahbw_bus_if_inst.busWaitRelease === 1'h0) begin
      lowCnt++;
    end
    if (wrValid === 1'h1) begin
      wrCount++;
    end
    // decode seen by the device in the cycle after the read started
    if (rdTaken === 1'h1) begin
      rdCount++;
      rdQm = accessIsQm;
      rdBe = accessBe;
    end
    if (cycles == 2000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    tbl[0] = '{1'h0, 15'h0007, 1'h1, 1'h0, 1'h1, 1'h0, 0, 1'h0};
    tbl[1] = '{1'h1, 15'h0007, 1'h1, 1'h0, 1'h0, 1'h0, 0, 1'h0};
    tbl[2] = '{1'h0, 15'h0004, 1'h1, 1'h0, 1'h1, 1'h0, 2, 1'h1};
    tbl[3] = '{1'h0, 15'h0004, 1'h1, 1'h0, 1'h0, 1'h1, 1, 1'h1};
    tbl[4] = '{1'h1, 15'h0004, 1'h1, 1'h0, 1'h1, 1'h0, 1, 1'h1};
    tbl[5] = '{1'h1, 15'h0004, 1'h1, 1'h0, 1'h0, 1'h0, 1, 1'h1};
    tbl[6] = '{1'h1, 15'h0010, 1'h0, 1'h1, 1'h0, 1'h0, 3, 1'h1};
    tbl[7] = '{1'h0, 15'h0010, 1'h0, 1'h1, 1'h0, 1'h0, 2, 1'h1};
    tbl[8] = '{1'h0, 15'h0004, 1'h0, 1'h0, 1'h0, 1'h0, 0, 1'h0};
    tbl[9] = '{1'h0, 15'h0183, 1'h1, 1'h0, 1'h1, 1'h0, 0, 1'h0};
    repeat (8) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    `CHK("idle ready", 1'h1, ahbw_bus_if_inst.busWaitRelease)
    `CHK("idle read strobe", 1'h1, ahbw_bus_if_inst.readStrobeN)
    `CHK("idle local select", 1'h1, ahbw_bus_if_inst.localDeviceSelectN)
    // clock enable low: a pending command must not be taken
    clkEn = 1'h0;
    cmdValid = 1'h1;
    cmdAddr = 15'h0183;
    repeat (3) @(negedge ref_clk);
    `CHK("frozen addr", 15'h0000, ahbw_bus_if_inst.addr)
    `CHK("frozen ready", 1'h1, ahbw_bus_if_inst.busWaitRelease)
    cmdValid = 1'h0;
    clkEn = 1'h1;
    @(negedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      access(i, 1'h1);
    end
    for (int i = 0; i < 10; i++) begin
      access(i, 1'h0);
    end
    waitIdle();
    `CHK("write count", 8, wrCount)
    `CHK("read count", 12, rdCount)
    results();
  end
endmodule : async_host_bus_wait_port_test
